// ### rtl/mode_ctrl_pkg.sv
// Shared constants for the converter control block and its host controller
package mode_ctrl_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          PARTIAL_MIN_NS   = 55;
    localparam int          PARTIAL_MAX_NS   = 2000;
    localparam int          FULL_MIN_NS      = 3000;
    localparam int          PARTIAL_SETUP_NS = 50;
    localparam int          FULL_SETUP_US    = 253;
    localparam int          POWER_UP_MS      = 10;
    localparam int          WAKE_UP_NS       = 1000;
    localparam int          PARTIAL_MIN_CYC  = (PARTIAL_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          PARTIAL_MAX_CYC  = PARTIAL_MAX_NS * CLK_MHZ / 1000;
    localparam int          FULL_MIN_CYC     = (FULL_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          PARTIAL_SETUP_CYC = (PARTIAL_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          FULL_SETUP_CYC   = FULL_SETUP_US * CLK_MHZ;
    localparam int          POWER_UP_CYC     = POWER_UP_MS * 1000 * CLK_MHZ;
    localparam int          WAKE_UP_CYC      = (WAKE_UP_NS * CLK_MHZ + 999) / 1000 + 1;
    localparam int          CONV_CYC         = 40;
    localparam logic [7:0]  STATUS_ADDR      = 8'h01;
    localparam logic [7:0]  CONFIG_ADDR      = 8'h02;
    localparam logic [7:0]  RATIO_ADDR       = 8'h08;
    localparam logic [7:0]  RANGE_ADDR       = 8'h03;
    localparam logic [7:0]  FEATURE_ADDR     = 8'h21;
    localparam int          RESET_DETECT_BIT = 7;
    localparam logic [7:0]  CONFIG_RESET     = 8'h00;
    localparam logic [7:0]  RATIO_RESET      = 8'h00;
    localparam logic [7:0]  RANGE_RESET      = 8'h00;
    localparam logic [7:0]  FEATURE_RESET    = 8'h00;
    localparam logic [3:0]  RATIO_MAX_SW     = 4'h8;
    localparam logic [2:0]  OS_SOFTWARE      = 3'h7;
    localparam logic [1:0]  LANES_HW         = 2'h1;
    typedef enum logic [1:0] {
        PWR_NORMAL  = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_AUTO    = 2'b10,
        PWR_SHUT    = 2'b11
    } power_t;
endpackage

// ### rtl/mode_ctrl_if.sv
// Pin-level link between the host controller and the converter control block
`timescale 1ns/10ps
interface mode_ctrl_if;
    logic       resetPin;
    logic       sampleTrigger;
    logic       standbyRequestN;
    logic       rangePin;
    logic [2:0] oversampleSelectPins;
    logic       interfaceTypePin;
    logic       refSelectPin;
    logic       busy;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    modport device (
        input  resetPin, sampleTrigger, standbyRequestN, rangePin, oversampleSelectPins,
        input  interfaceTypePin, refSelectPin, regWrite, regRead, regAddr, regWdata,
        output busy, regRdata
    );
    modport host (
        output resetPin, sampleTrigger, standbyRequestN, rangePin, oversampleSelectPins,
        output interfaceTypePin, refSelectPin, regWrite, regRead, regAddr, regWdata,
        input  busy, regRdata
    );
endinterface

// ### rtl/adc_mode_reset_power_ctrl.sv
// Converter control end: mode select, reset decode, power states, registers
`timescale 1ns/10ps
module adc_mode_reset_power_ctrl #(
    parameter int CONV_CYCLES = mode_ctrl_pkg::CONV_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    mode_ctrl_if.device     link,
    output logic            softwareMode,
    output logic [8:0]      averagingRatio,
    output logic [1:0]      powerState,
    output logic            serialMode,
    output logic            internalRef,
    output logic [1:0]      serialLanes,
    output logic [7:0]      channelRange,
    output logic            featuresEnabled,
    output logic            partialResetPulse,
    output logic            resultValid
);
    typedef struct packed {
        logic [15:0] pulseCnt;
        logic        prevReset;
        logic        prevTrig;
        logic        prevBusy;
        logic        swMode;
        logic        serMode;
        logic [2:0]  hwRatioCode;
        logic [7:0]  config_;
        logic [7:0]  ratioReg;
        logic [7:0]  rangeReg;
        logic [7:0]  featureReg;
        logic        resetDetect;
        logic        busy;
        logic [15:0] convCnt;
        logic        asleep;
        logic        valid;
        logic        partial;
        logic [7:0]  rdata;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;
    logic   trigRise;
    logic   resetFall;
    logic   partialHit;
    logic   fullHit;
    logic [1:0] pwr;

    always_comb begin
        trigRise   = link.sampleTrigger && !cur_ff.prevTrig;
        resetFall  = !link.resetPin && cur_ff.prevReset;
        partialHit = resetFall && cur_ff.pulseCnt >= 16'(mode_ctrl_pkg::PARTIAL_MIN_CYC)
                     && cur_ff.pulseCnt <= 16'(mode_ctrl_pkg::PARTIAL_MAX_CYC);
        fullHit    = resetFall
                     && cur_ff.pulseCnt >= 16'(mode_ctrl_pkg::FULL_MIN_CYC);
        if (!cur_ff.swMode) begin
            if (link.standbyRequestN) begin
                pwr = mode_ctrl_pkg::PWR_NORMAL;
            end else begin
                pwr = link.rangePin ? mode_ctrl_pkg::PWR_STANDBY : mode_ctrl_pkg::PWR_SHUT;
            end
        end else begin
            pwr = cur_ff.config_[1:0];
        end
        nxt_cur           = cur_ff;
        nxt_cur.prevReset = link.resetPin;
        nxt_cur.prevTrig  = link.sampleTrigger;
        nxt_cur.prevBusy  = cur_ff.busy;
        nxt_cur.partial   = partialHit;
        nxt_cur.rdata     = 8'h00;
        if (link.resetPin) begin
            if (cur_ff.pulseCnt != 16'hffff) begin
                nxt_cur.pulseCnt = cur_ff.pulseCnt + 16'h0001;
            end
        end else begin
            nxt_cur.pulseCnt = 16'h0000;
        end
        // Conversion timing; busy falls when all channels finish
        if (cur_ff.busy) begin
            if (cur_ff.convCnt == 16'h0000) begin
                nxt_cur.busy  = 1'b0;
                nxt_cur.valid = 1'b1;
                if (!cur_ff.swMode) begin
                    nxt_cur.hwRatioCode = link.oversampleSelectPins;
                end
            end else begin
                nxt_cur.convCnt = cur_ff.convCnt - 16'h0001;
            end
        end else if (trigRise && !link.resetPin && pwr != mode_ctrl_pkg::PWR_SHUT
                     && !(pwr == mode_ctrl_pkg::PWR_STANDBY)) begin
            nxt_cur.busy    = 1'b1;
            nxt_cur.valid   = 1'b0;
            nxt_cur.convCnt = 16'(CONV_CYCLES - 1);
            nxt_cur.asleep  = 1'b0;
        end
        if (pwr == mode_ctrl_pkg::PWR_AUTO && cur_ff.prevBusy && !cur_ff.busy) begin
            nxt_cur.asleep = 1'b1;
        end
        if (pwr != mode_ctrl_pkg::PWR_AUTO) begin
            nxt_cur.asleep = 1'b0;
        end
        // Register port; feature registers only in software mode
        if (link.regWrite && cur_ff.swMode) begin
            unique case (link.regAddr)
                mode_ctrl_pkg::CONFIG_ADDR:  nxt_cur.config_    = link.regWdata;
                mode_ctrl_pkg::RATIO_ADDR:   nxt_cur.ratioReg   = link.regWdata;
                mode_ctrl_pkg::RANGE_ADDR:   nxt_cur.rangeReg   = link.regWdata;
                mode_ctrl_pkg::FEATURE_ADDR: nxt_cur.featureReg = link.regWdata;
                default: ;
            endcase
        end
        if (link.regRead) begin
            unique case (link.regAddr)
                mode_ctrl_pkg::STATUS_ADDR: begin
                    nxt_cur.rdata = {cur_ff.resetDetect, 7'h00};
                    nxt_cur.resetDetect = 1'b0;
                end
                mode_ctrl_pkg::CONFIG_ADDR:  nxt_cur.rdata = cur_ff.config_;
                mode_ctrl_pkg::RATIO_ADDR:   nxt_cur.rdata = cur_ff.ratioReg;
                mode_ctrl_pkg::RANGE_ADDR:   nxt_cur.rdata = cur_ff.rangeReg;
                mode_ctrl_pkg::FEATURE_ADDR: nxt_cur.rdata = cur_ff.featureReg;
                default:                     nxt_cur.rdata = 8'h00;
            endcase
        end
        // Any reset pulse held high aborts the running conversion
        if (link.resetPin) begin
            nxt_cur.busy  = 1'b0;
            nxt_cur.valid = 1'b0;
        end
        if (partialHit) begin
            nxt_cur.asleep      = 1'b0;
            nxt_cur.resetDetect = 1'b1;
        end
        if (fullHit) begin
            nxt_cur.config_     = mode_ctrl_pkg::CONFIG_RESET;
            nxt_cur.ratioReg    = mode_ctrl_pkg::RATIO_RESET;
            nxt_cur.rangeReg    = mode_ctrl_pkg::RANGE_RESET;
            nxt_cur.featureReg  = mode_ctrl_pkg::FEATURE_RESET;
            nxt_cur.asleep      = 1'b0;
            nxt_cur.swMode      = link.oversampleSelectPins == mode_ctrl_pkg::OS_SOFTWARE;
            nxt_cur.serMode     = link.interfaceTypePin;
            nxt_cur.hwRatioCode = link.oversampleSelectPins;
            nxt_cur.resetDetect = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    always_comb begin
        logic [3:0] code;
        code = 4'h0;
        if (cur_ff.swMode) begin
            code = (cur_ff.ratioReg[3:0] > mode_ctrl_pkg::RATIO_MAX_SW) ?
                   4'h0 : cur_ff.ratioReg[3:0];
        end else begin
            code = {1'b0, cur_ff.hwRatioCode};
        end
        averagingRatio = 9'h001 << code;
    end

    assign link.busy         = cur_ff.busy;
    assign link.regRdata     = cur_ff.rdata;
    assign softwareMode      = cur_ff.swMode;
    assign powerState        = cur_ff.asleep ? mode_ctrl_pkg::PWR_STANDBY : pwr;
    assign serialMode        = cur_ff.serMode;
    assign internalRef       = link.refSelectPin;
    assign serialLanes       = cur_ff.swMode ? cur_ff.config_[4:3] : mode_ctrl_pkg::LANES_HW;
    assign channelRange      = cur_ff.swMode ? cur_ff.rangeReg : {8{link.rangePin}};
    assign featuresEnabled   = cur_ff.swMode && cur_ff.featureReg[0];
    assign partialResetPulse = cur_ff.partial;
    assign resultValid       = cur_ff.valid;
endmodule

// ### rtl/adc_host_ctrl.sv
// Host end: drives reset pulses, trigger, straps and register access
`timescale 1ns/10ps
module adc_host_ctrl #(
    parameter int FULL_SETUP_CYCLES = mode_ctrl_pkg::FULL_SETUP_CYC,
    parameter int POWER_UP_CYCLES   = mode_ctrl_pkg::POWER_UP_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    mode_ctrl_if.host       link,
    input  wire logic       partialReq,
    input  wire logic       fullReq,
    input  wire logic       convertReq,
    input  wire logic       wakeReq,
    input  wire logic [2:0] osStrap,
    input  wire logic       standbyN,
    input  wire logic       range,
    input  wire logic       serialSel,
    input  wire logic       refSel,
    input  wire logic       wrReq,
    input  wire logic       rdReq,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            ready,
    output logic            busyOut
);
    typedef enum logic [2:0] {
        H_IDLE    = 3'b000,
        H_RESET   = 3'b001,
        H_SETUP   = 3'b010,
        H_LOWTRIG = 3'b011,
        H_TRIG    = 3'b100,
        H_POWERUP = 3'b101
    } hstate_t;
    typedef struct packed {
        hstate_t     st;
        logic [31:0] cnt;
        logic        full;
        logic        resetPin;
        logic        trig;
    } host_t;

    host_t cur_ff;
    host_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        unique case (cur_ff.st)
            H_IDLE: begin
                if (wakeReq) begin
                    nxt_cur.st  = H_POWERUP;
                    nxt_cur.cnt = 32'(POWER_UP_CYCLES - 1);
                end else if (fullReq || partialReq) begin
                    nxt_cur.st       = H_RESET;
                    nxt_cur.full     = fullReq;
                    nxt_cur.resetPin = 1'b1;
                    nxt_cur.cnt      = fullReq ? 32'(mode_ctrl_pkg::FULL_MIN_CYC - 1)
                                               : 32'(mode_ctrl_pkg::PARTIAL_MIN_CYC - 1);
                end else if (convertReq && !link.busy) begin
                    nxt_cur.st   = H_LOWTRIG;
                    nxt_cur.trig = 1'b0;
                    nxt_cur.cnt  = 32'(mode_ctrl_pkg::WAKE_UP_CYC - 1);
                end
            end
            H_POWERUP: begin
                if (cur_ff.cnt == 32'h0) begin
                    nxt_cur.st       = H_RESET;
                    nxt_cur.full     = 1'b1;
                    nxt_cur.resetPin = 1'b1;
                    nxt_cur.cnt      = 32'(mode_ctrl_pkg::FULL_MIN_CYC - 1);
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 32'h1;
                end
            end
            H_RESET: begin
                if (cur_ff.cnt == 32'h0) begin
                    nxt_cur.resetPin = 1'b0;
                    nxt_cur.st       = H_SETUP;
                    nxt_cur.cnt      = cur_ff.full ? 32'(FULL_SETUP_CYCLES - 1)
                                       : 32'(mode_ctrl_pkg::PARTIAL_SETUP_CYC - 1);
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 32'h1;
                end
            end
            H_SETUP, H_LOWTRIG: begin
                if (cur_ff.cnt == 32'h0) begin
                    nxt_cur.st   = (cur_ff.st == H_LOWTRIG) ? H_TRIG : H_IDLE;
                    nxt_cur.trig = cur_ff.st == H_LOWTRIG;
                end else begin
                    nxt_cur.cnt = cur_ff.cnt - 32'h1;
                end
            end
            H_TRIG: begin
                nxt_cur.trig = 1'b0;
                nxt_cur.st   = H_IDLE;
            end
            default: nxt_cur.st = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign link.resetPin             = cur_ff.resetPin;
    assign link.sampleTrigger        = cur_ff.trig;
    assign link.standbyRequestN      = standbyN;
    assign link.rangePin             = range;
    assign link.oversampleSelectPins = osStrap;
    assign link.interfaceTypePin     = serialSel;
    assign link.refSelectPin         = refSel;
    assign link.regWrite             = wrReq;
    assign link.regRead              = rdReq;
    assign link.regAddr              = addr;
    assign link.regWdata             = wdata;
    assign rdata                     = link.regRdata;
    assign ready                     = cur_ff.st == H_IDLE;
    assign busyOut                   = link.busy;
endmodule

// ### test/adc_mode_reset_power_ctrl_props.sv
// Concurrent checks on the pin link between host and converter control
`timescale 1ns/10ps
module adc_mode_reset_power_ctrl_props #(
    parameter int CONV_CYCLES       = mode_ctrl_pkg::CONV_CYC,
    parameter int FULL_SETUP_CYCLES = mode_ctrl_pkg::FULL_SETUP_CYC
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       resetPin,
    input wire logic       sampleTrigger,
    input wire logic       busy,
    input wire logic       regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regRdata
);
    logic [15:0] rstHigh_ff;
    logic [15:0] busyCnt_ff;
    logic [15:0] lowCnt_ff;
    logic [15:0] setupCnt_ff;
    logic [15:0] setupNeed_ff;
    logic        abort_ff;
    logic        rstOk;
    logic        mapped;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    assign rstOk  = (rstHigh_ff >= 16'h0006 && rstHigh_ff <= 16'h00c8) || rstHigh_ff >= 16'h012c;
    assign mapped = regAddr inside {8'h01, 8'h02, 8'h03, 8'h08, 8'h21};

    // Pulse lengths, busy time, trigger low time and time since release
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rstHigh_ff   <= 16'h0000;
            busyCnt_ff   <= 16'h0000;
            lowCnt_ff    <= 16'h0000;
            setupCnt_ff  <= 16'hffff;
            setupNeed_ff <= 16'h0000;
            abort_ff     <= 1'b0;
        end else begin
            rstHigh_ff <= resetPin ? rstHigh_ff + 16'h0001 : 16'h0000;
            busyCnt_ff <= busy ? busyCnt_ff + 16'h0001 : 16'h0000;
            abort_ff   <= busy ? (abort_ff | resetPin) : 1'b0;
            if (sampleTrigger) begin
                lowCnt_ff <= 16'h0000;
            end else if (lowCnt_ff != 16'hffff) begin
                lowCnt_ff <= lowCnt_ff + 16'h0001;
            end
            if ($fell(resetPin)) begin
                setupCnt_ff  <= 16'h0000;
                setupNeed_ff <= (rstHigh_ff >= 16'h012c) ? 16'(FULL_SETUP_CYCLES - 1) : 16'h0004;
            end else if (setupCnt_ff != 16'hffff) begin
                setupCnt_ff <= setupCnt_ff + 16'h0001;
            end
        end
    end

    sequence s_resetDone;
        $fell(resetPin) && rstOk;
    endsequence
    sequence s_statusRead;
        regRead && regAddr == mode_ctrl_pkg::STATUS_ADDR && !$past(regRead);
    endsequence

    property p_busyCause;
        $rose(busy) |-> $past(sampleTrigger);
    endproperty
    property p_busyLen;
        $fell(busy) && !abort_ff |-> busyCnt_ff == 16'(CONV_CYCLES);
    endproperty
    property p_rdIdle;
        !$past(regRead) |-> regRdata == 8'h00;
    endproperty
    property p_unmapped;
        regRead && !mapped |=> regRdata == 8'h00;
    endproperty
    property p_detect;
        s_resetDone ##2 s_statusRead |=> regRdata[7];
    endproperty
    property p_trigPulse;
        $rose(sampleTrigger) |=> !sampleTrigger;
    endproperty
    property p_wake;
        $rose(sampleTrigger) |-> lowCnt_ff > 16'h0064;
    endproperty
    property p_rstLen;
        $fell(resetPin) |-> rstOk;
    endproperty
    property p_setup;
        $rose(sampleTrigger) |-> setupCnt_ff >= setupNeed_ff;
    endproperty

    a_busyCause: assert property (p_busyCause) else $error("busy rose without a trigger");
    a_busyLen: assert property (p_busyLen) else $error("busy time differs from conversion length");
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside its read slot");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
    a_detect: assert property (p_detect) else $error("reset detect flag not set");
    a_trigPulse: assert property (p_trigPulse) else $error("trigger longer than one cycle");
    a_wake: assert property (p_wake) else $error("trigger low time too short");
    a_rstLen: assert property (p_rstLen) else $error("reset pulse of undefined length");
    a_setup: assert property (p_setup) else $error("trigger before device setup time");
endmodule

// ### test/adc_mode_reset_power_ctrl_tb.sv
// Self-checking bench joining the host end and the converter control end
`timescale 1ns/10ps
module adc_mode_reset_power_ctrl_tb;
    localparam int CONV_N  = mode_ctrl_pkg::CONV_CYC;
    localparam int SETUP_N = 50;
    typedef struct packed {
        logic [2:0] os;
        logic       sbyReqN;
        logic       rng;
        logic       ser;
        logic       refp;
        logic [8:0] ratio;
        logic [1:0] pwr;
        logic       sw;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 9'h001, 2'h0, 1'b0},
        '{3'h1, 1'b0, 1'b1, 1'b1, 1'b0, 9'h002, 2'h1, 1'b0},
        '{3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 9'h004, 2'h3, 1'b0},
        '{3'h3, 1'b1, 1'b1, 1'b1, 1'b1, 9'h008, 2'h0, 1'b0},
        '{3'h4, 1'b1, 1'b0, 1'b0, 1'b0, 9'h010, 2'h0, 1'b0},
        '{3'h5, 1'b0, 1'b1, 1'b1, 1'b1, 9'h020, 2'h1, 1'b0},
        '{3'h6, 1'b1, 1'b1, 1'b0, 1'b0, 9'h040, 2'h0, 1'b0},
        '{3'h7, 1'b1, 1'b0, 1'b1, 1'b1, 9'h001, 2'h3, 1'b1}};

    logic       mclk, rst, wakeReq, standbyN, rangeLvl, serialSel, refSel, wrReq, rdReq;
    logic [2:0] req, osStrap;
    logic [7:0] addr, wdata, rdata, channelRange, d;
    logic       ready, busyOut, softwareMode, serialMode, internalRef;
    logic       featuresEnabled, partialResetPulse, resultValid;
    logic [8:0] averagingRatio;
    logic [1:0] powerState, serialLanes;
    int         fails, testsRun, n;

    mode_ctrl_if link ();
    adc_host_ctrl #(.FULL_SETUP_CYCLES(SETUP_N), .POWER_UP_CYCLES(100)) i_adc_host_ctrl (
        .mclk(mclk), .rst(rst), .link(link), .partialReq(req[0]), .fullReq(req[1]),
        .convertReq(req[2]), .wakeReq(wakeReq), .osStrap(osStrap), .standbyN(standbyN),
        .range(rangeLvl), .serialSel(serialSel), .refSel(refSel), .wrReq(wrReq),
        .rdReq(rdReq), .addr(addr), .wdata(wdata), .rdata(rdata), .ready(ready),
        .busyOut(busyOut));
    adc_mode_reset_power_ctrl #(.CONV_CYCLES(CONV_N)) i_adc_mode_reset_power_ctrl (
        .mclk(mclk), .rst(rst), .link(link), .softwareMode(softwareMode),
        .averagingRatio(averagingRatio), .powerState(powerState), .serialMode(serialMode),
        .internalRef(internalRef), .serialLanes(serialLanes), .channelRange(channelRange),
        .featuresEnabled(featuresEnabled), .partialResetPulse(partialResetPulse),
        .resultValid(resultValid));
    adc_mode_reset_power_ctrl_props #(.CONV_CYCLES(CONV_N), .FULL_SETUP_CYCLES(SETUP_N))
        i_adc_mode_reset_power_ctrl_props (.mclk(mclk), .rst(rst), .resetPin(link.resetPin),
        .sampleTrigger(link.sampleTrigger), .busy(link.busy), .regRead(link.regRead),
        .regAddr(link.regAddr), .regRdata(link.regRdata));

    task automatic wrapUp();
        $display("checks run %0d, mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        testsRun++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t ns: %s", $time, msg);
        end
    endtask
    task automatic tick(input int lim);
        @(posedge mclk);
        #1;
        n++;
        if (n > lim) begin
            check(1'b0, "wait limit ran out");
            wrapUp();
        end
    endtask
    task automatic pulseReq(input logic [2:0] v);
        @(posedge mclk);
        req <= v;
        @(posedge mclk);
        req <= 3'h0;
    endtask
    task automatic waitReady();
        n = 0;
        repeat (3) @(posedge mclk);
        while (ready !== 1'b1) tick(2000);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        wrReq <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wrReq <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        rdReq <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rdReq <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic conv();
        pulseReq(3'h4);
        n = 0;
        while (busyOut !== 1'b1) tick(400);
        n = 0;
        while (busyOut === 1'b1) tick(400);
        check(n == CONV_N && resultValid === 1'b1, "conversion length or result flag");
    endtask

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        {rst, req, wakeReq, osStrap, standbyN, rangeLvl} = 10'h200;
        {serialSel, refSel, wrReq, rdReq, addr, wdata} = 20'h00000;
        fails = 0;
        testsRun = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        foreach (ROWS[i]) begin
            @(posedge mclk);
            osStrap <= ROWS[i].os;
            standbyN <= ROWS[i].sbyReqN;
            rangeLvl <= ROWS[i].rng;
            serialSel <= ROWS[i].ser;
            refSel <= ROWS[i].refp;
            pulseReq(3'h2);
            waitReady();
            wr(mode_ctrl_pkg::CONFIG_ADDR, 8'h03);
            wr(mode_ctrl_pkg::FEATURE_ADDR, 8'h01);
            @(posedge mclk);
            #1;
            check(softwareMode === ROWS[i].sw, "mode select");
            check(averagingRatio === ROWS[i].ratio, "averaging ratio");
            check(powerState === ROWS[i].pwr, "power state");
            check(serialMode === ROWS[i].ser && internalRef === ROWS[i].refp, "pin selects");
            check(channelRange === (ROWS[i].sw ? 8'h00 : {8{ROWS[i].rng}}), "span");
            check(featuresEnabled === ROWS[i].sw, "feature access");
            check(ROWS[i].sw || serialLanes === mode_ctrl_pkg::LANES_HW, "lanes");
        end
        @(posedge mclk);
        wakeReq <= 1'b1;
        @(posedge mclk);
        wakeReq <= 1'b0;
        repeat (50) @(posedge mclk);
        #1;
        check(link.resetPin === 1'b0 && ready === 1'b0, "power-up wait before reset");
        waitReady();
        rd(mode_ctrl_pkg::CONFIG_ADDR, d);
        check(d === mode_ctrl_pkg::CONFIG_RESET, "defaults after full reset");
        wr(mode_ctrl_pkg::RATIO_ADDR, 8'h08);
        wr(mode_ctrl_pkg::CONFIG_ADDR, 8'h10);
        @(posedge mclk);
        #1;
        check(averagingRatio === 9'h100 && serialLanes === 2'h2, "ratio or lanes");
        rd(8'h40, d);
        check(d === 8'h00, "unmapped read");
        conv();
        pulseReq(3'h1);
        n = 0;
        while (link.resetPin !== 1'b1) tick(50);
        while (link.resetPin === 1'b1) tick(400);
        @(posedge mclk);
        #1;
        check(partialResetPulse === 1'b1, "partial reset pulse");
        @(posedge mclk);
        rdReq <= 1'b1;
        addr <= mode_ctrl_pkg::STATUS_ADDR;
        @(posedge mclk);
        rdReq <= 1'b0;
        #1;
        check(rdata[7] === 1'b1 && resultValid === 1'b0, "detect or discard");
        rd(mode_ctrl_pkg::STATUS_ADDR, d);
        check(d[7] === 1'b0, "detect flag clear on read");
        rd(mode_ctrl_pkg::CONFIG_ADDR, d);
        check(d === 8'h10 && averagingRatio === 9'h100, "config kept");
        waitReady();
        wr(mode_ctrl_pkg::CONFIG_ADDR, 8'h02);
        conv();
        repeat (2) @(posedge mclk);
        #1;
        check(powerState === mode_ctrl_pkg::PWR_STANDBY, "autostandby sleep");
        conv();
        wr(mode_ctrl_pkg::CONFIG_ADDR, 8'h01);
        wr(mode_ctrl_pkg::CONFIG_ADDR, 8'h00);
        conv();
        wrapUp();
    end
endmodule
